// ### verilog/rmcg_top.sv
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
// Notes on behaviour
// R01: each gating bit clocks one unit
// R02: access to unclocked unit gives bus fault
// R03: all gating bits reset to zero
// R04: run register sets enables in run
// R05: sleep registers apply only with auto gating
// R06: bits 18..16 gate timers 2..0
// R07: bit 12 gates two-wire unit 0
// R08: bit 4 gates synchronous serial unit 0
// R09: bits 1,0 gate serial ports 1,0
// R10: software preserves reserved bits on update
// R11: register decoded at offset 0x104
// R12: software enables units before using them
// R13: reserved bits read zero, ignore writes
module rmcg_top import rmcg_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // power state from the power controller, same clock
  input wire logic [1:0] power_state,
  // peripheral access check
  input rmcg_per_req_s per_req,
  output logic per_fault,
  // unit clock enables
  output rmcg_enables_s unit_clock_en,
  // interrupt
  output logic irq
);

  logic [31:0] run_gate_ff;
  logic [31:0] sleep_gate_ff;
  logic [31:0] deep_gate_ff;
  logic [31:0] run_cfg_ff;
  logic [31:0] fault_stat_ff;
  logic [31:0] fault_mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  rmcg_apb_st_e state_ff;
  rmcg_apb_st_e nxt_state;
  logic [31:0] nxt_rdata;
  logic nxt_err;
  logic [31:0] wr_bits;
  logic wr_en;
  logic fault_evt;
  logic [1:0] power_state_ff;

  function automatic logic [31:0] merge_word(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb, input logic [31:0] wmask);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m & wmask; // see R13
  endfunction

  // one-shot write in the access phase; pready answers one cycle after setup
  assign wr_en = psel && penable && pwrite && state_ff == RMCG_ST_ACCESS;
  assign wr_bits = pwdata;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RMCG_ST_IDLE: begin
        if (psel && !penable) begin
          nxt_state = RMCG_ST_ACCESS;
        end
      end
      RMCG_ST_ACCESS: begin
        nxt_state = RMCG_ST_DONE;
      end
      RMCG_ST_DONE: begin
        nxt_state = (psel && !penable) ? RMCG_ST_ACCESS : RMCG_ST_IDLE;
      end
      default: begin
        nxt_state = RMCG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= RMCG_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // read decode, reserved bits read zero
  always_comb begin
    nxt_rdata = 32'h00000000;
    nxt_err = 1'b0;
    unique case (paddr)
      RMCG_OFF_RUN_GATE: nxt_rdata = run_gate_ff; // see R11
      RMCG_OFF_SLEEP_GATE: nxt_rdata = sleep_gate_ff;
      RMCG_OFF_DEEP_GATE: nxt_rdata = deep_gate_ff;
      RMCG_OFF_RUN_CFG: nxt_rdata = run_cfg_ff;
      RMCG_OFF_FAULT_STAT: nxt_rdata = fault_stat_ff;
      RMCG_OFF_FAULT_MASK: nxt_rdata = fault_mask_ff;
      RMCG_OFF_POWER_STATE: nxt_rdata = {30'h0, power_state_ff};
      default: nxt_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= psel && !penable;
      pslverr_ff <= psel && !penable && nxt_err;
      prdata_ff <= (psel && !penable && !pwrite) ? nxt_rdata : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_state_ff <= RMCG_PWR_RUN;
    end else begin
      power_state_ff <= power_state;
    end
  end

  // run gating word; unit bits 18..16, 12, 4, 1, 0 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_gate_ff <= RMCG_GATE_RESET; // see R03
    end else if (wr_en && paddr == RMCG_OFF_RUN_GATE) begin // see R11
      run_gate_ff <= merge_word(run_gate_ff, wr_bits, pstrb, RMCG_GATE_WMASK); // see R06 R07 R08 R09
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_gate_ff <= RMCG_GATE_RESET;
    end else if (wr_en && paddr == RMCG_OFF_SLEEP_GATE) begin
      sleep_gate_ff <= merge_word(sleep_gate_ff, wr_bits, pstrb, RMCG_GATE_WMASK); // see R05
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deep_gate_ff <= RMCG_GATE_RESET;
    end else if (wr_en && paddr == RMCG_OFF_DEEP_GATE) begin
      deep_gate_ff <= merge_word(deep_gate_ff, wr_bits, pstrb, RMCG_GATE_WMASK); // see R05
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cfg_ff <= RMCG_CFG_RESET;
    end else if (wr_en && paddr == RMCG_OFF_RUN_CFG) begin
      run_cfg_ff <= merge_word(run_cfg_ff, wr_bits, pstrb, RMCG_CFG_WMASK); // see R05
    end
  end

  // bit 0 of the status records any bus fault on a gated unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_mask_ff <= RMCG_FAULT_RESET;
    end else if (wr_en && paddr == RMCG_OFF_FAULT_MASK) begin
      fault_mask_ff <= merge_word(fault_mask_ff, wr_bits, pstrb, RMCG_FAULT_WMASK);
    end
  end

  // set wins over a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_stat_ff <= RMCG_FAULT_RESET;
    end else begin
      if (wr_en && paddr == RMCG_OFF_FAULT_STAT && pstrb[RMCG_BIT_FAULT / 8]) begin
        fault_stat_ff[RMCG_BIT_FAULT] <= fault_stat_ff[RMCG_BIT_FAULT] & ~wr_bits[RMCG_BIT_FAULT];
      end
      if (fault_evt) begin
        fault_stat_ff[RMCG_BIT_FAULT] <= 1'b1; // see R02
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(fault_stat_ff & fault_mask_ff);
    end
  end

  rmcg_gate_select u_gate_select (
    .pclk(pclk),
    .presetn(presetn),
    .run_word(run_gate_ff),
    .sleep_word(sleep_gate_ff),
    .deep_word(deep_gate_ff),
    .auto_gate(run_cfg_ff[RMCG_BIT_AUTO_GATE]),
    .power_state(power_state_ff),
    .enables(unit_clock_en)
  );

  rmcg_fault_check u_fault_check (
    .pclk(pclk),
    .presetn(presetn),
    .enables(unit_clock_en),
    .req(per_req),
    .fault(fault_evt)
  );

  assign per_fault = fault_evt;
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;

endmodule

// ### verilog/rmcg_pkg.sv
package rmcg_pkg;

  // register offsets within the system control window
  localparam logic [11:0] RMCG_OFF_RUN_GATE = 12'h104;
  localparam logic [11:0] RMCG_OFF_SLEEP_GATE = 12'h114;
  localparam logic [11:0] RMCG_OFF_DEEP_GATE = 12'h124;
  localparam logic [11:0] RMCG_OFF_RUN_CFG = 12'h060;
  localparam logic [11:0] RMCG_OFF_FAULT_STAT = 12'h200;
  localparam logic [11:0] RMCG_OFF_FAULT_MASK = 12'h204;
  localparam logic [11:0] RMCG_OFF_POWER_STATE = 12'h208;
  localparam logic [31:0] RMCG_SYSCTL_BASE = 32'h400fe000;

  // gating register fields
  localparam int RMCG_BIT_TIMER_UNIT2_CLOCK_ON = 18;
  localparam int RMCG_BIT_TIMER_UNIT1_CLOCK_ON = 17;
  localparam int RMCG_BIT_TIMER_UNIT0_CLOCK_ON = 16;
  localparam int RMCG_BIT_TWOWIRE0 = 12;
  localparam int RMCG_BIT_SYNC0 = 4;
  localparam int RMCG_BIT_SERIAL1 = 1;
  localparam int RMCG_BIT_SERIAL0 = 0;
  localparam logic [31:0] RMCG_GATE_WMASK = 32'h00071013;
  localparam logic [31:0] RMCG_GATE_RESET = 32'h00000000;

  // run clock configuration: auto gating select bit
  localparam int RMCG_BIT_AUTO_GATE = 27;
  localparam logic [31:0] RMCG_CFG_WMASK = 32'h08000000;
  localparam logic [31:0] RMCG_CFG_RESET = 32'h00000000;

  // fault status and mask: one sticky bit
  localparam int RMCG_BIT_FAULT = 0;
  localparam logic [31:0] RMCG_FAULT_WMASK = 32'h00000001;
  localparam logic [31:0] RMCG_FAULT_RESET = 32'h00000000;

  localparam int RMCG_NUM_UNITS = 7;
  localparam logic [1:0] RMCG_PWR_RUN = 2'h0;
  localparam logic [1:0] RMCG_PWR_SLEEP = 2'h1;
  localparam logic [1:0] RMCG_PWR_DEEP = 2'h2;

  typedef struct packed {
    logic timer_unit2_clock_on;
    logic timer_unit1_clock_on;
    logic timer_unit0_clock_on;
    logic twowire_unit0_clock_on;
    logic sync_serial0_clock_on;
    logic serial_port1_clock_on;
    logic serial_port0_clock_on;
  } rmcg_enables_s;

  // peripheral-side access request: valid flag and unit index
  typedef struct packed {
    logic valid;
    logic [2:0] unit;
  } rmcg_per_req_s;

  typedef enum logic [2:0] {
    RMCG_ST_IDLE = 3'b001,
    RMCG_ST_ACCESS = 3'b010,
    RMCG_ST_DONE = 3'b100
  } rmcg_apb_st_e;

  function automatic rmcg_enables_s rmcg_unpack(input logic [31:0] w);
    rmcg_enables_s e;
    e.timer_unit2_clock_on = w[RMCG_BIT_TIMER_UNIT2_CLOCK_ON];
    e.timer_unit1_clock_on = w[RMCG_BIT_TIMER_UNIT1_CLOCK_ON];
    e.timer_unit0_clock_on = w[RMCG_BIT_TIMER_UNIT0_CLOCK_ON];
    e.twowire_unit0_clock_on = w[RMCG_BIT_TWOWIRE0];
    e.sync_serial0_clock_on = w[RMCG_BIT_SYNC0];
    e.serial_port1_clock_on = w[RMCG_BIT_SERIAL1];
    e.serial_port0_clock_on = w[RMCG_BIT_SERIAL0];
    return e;
  endfunction

endpackage

// ### verilog/rmcg_gate_select.sv
`timescale 1ns/100ps
module rmcg_gate_select import rmcg_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // gating words
  input wire logic [31:0] run_word,
  input wire logic [31:0] sleep_word,
  input wire logic [31:0] deep_word,
  // mode
  input wire logic auto_gate,
  input wire logic [1:0] power_state,
  // selected enables, registered
  output rmcg_enables_s enables
);

  rmcg_enables_s enables_ff;
  rmcg_enables_s nxt_enables;

  // sleep words only take over when auto gating is selected
  always_comb begin
    nxt_enables = rmcg_unpack(run_word); // see R04
    if (auto_gate && power_state == RMCG_PWR_SLEEP) begin
      nxt_enables = rmcg_unpack(sleep_word); // see R05
    end else if (auto_gate && power_state == RMCG_PWR_DEEP) begin
      nxt_enables = rmcg_unpack(deep_word); // see R05
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enables_ff <= '0; // see R03
    end else begin
      enables_ff <= nxt_enables; // see R01
    end
  end

  assign enables = enables_ff;

endmodule

// ### verilog/rmcg_fault_check.sv
`timescale 1ns/100ps
module rmcg_fault_check import rmcg_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // current enables and access request
  input rmcg_enables_s enables,
  input rmcg_per_req_s req,
  // fault pulse, registered
  output logic fault
);

  logic fault_ff;
  logic [RMCG_NUM_UNITS-1:0] en_vec;
  logic [7:0] en_pad;

  assign en_vec = enables;
  // spare index 7 reads as a cleared enable, so it always faults
  assign en_pad = {1'b0, en_vec};

  // unit index 0..6 follows the struct order from the bottom bit upward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_ff <= 1'b0;
    end else begin
      fault_ff <= req.valid && !en_pad[req.unit]; // see R02
    end
  end

  assign fault = fault_ff;

endmodule

// ### test/rmcg_chk.sv
`timescale 1ns/100ps
module rmcg_chk import rmcg_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // units
  input wire logic [1:0] power_state,
  input rmcg_per_req_s per_req,
  input wire logic per_fault,
  input rmcg_enables_s unit_clock_en
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [6:0] en;
  logic [6:0] wgate;
  logic mapped;
  assign en = unit_clock_en;
  assign wgate = {pwdata[RMCG_BIT_TIMER_UNIT2_CLOCK_ON], pwdata[RMCG_BIT_TIMER_UNIT1_CLOCK_ON], pwdata[RMCG_BIT_TIMER_UNIT0_CLOCK_ON],
    pwdata[RMCG_BIT_TWOWIRE0], pwdata[RMCG_BIT_SYNC0], pwdata[RMCG_BIT_SERIAL1],
    pwdata[RMCG_BIT_SERIAL0]};
  assign mapped = paddr inside {RMCG_OFF_RUN_GATE, RMCG_OFF_SLEEP_GATE, RMCG_OFF_DEEP_GATE,
    RMCG_OFF_RUN_CFG, RMCG_OFF_FAULT_STAT, RMCG_OFF_FAULT_MASK, RMCG_OFF_POWER_STATE};
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  // power state must hold, it is registered inside before selection
  sequence run_wr_s;
    (power_state == RMCG_PWR_RUN) [*2] ##0
      (access_s and (pwrite && pstrb == 4'hf && paddr == RMCG_OFF_RUN_GATE));
  endsequence
  rdy_zero_wait_a: assert property (setup_s |=> access_s)
    else $error("pready not in access cycle");
  rdy_single_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_mapped_a: assert property (pready && mapped |-> !pslverr)
    else $error("error on mapped offset");
  err_unmapped_a: assert property (pready && !mapped |-> pslverr)
    else $error("no error on unmapped offset");
  rd_reserved_a: assert property (pready && !pwrite && paddr == RMCG_OFF_RUN_GATE
    |-> (prdata & ~RMCG_GATE_WMASK) == 32'h0)
    else $error("reserved gate bits read nonzero");
  en_write_a: assert property (run_wr_s |-> ##2 en == $past(wgate, 2))
    else $error("enables do not follow gate write");
  fault_off_a: assert property (per_req.valid && per_req.unit != 3'h7 && !en[per_req.unit]
    |=> per_fault)
    else $error("no fault for unclocked unit");
  fault_on_a: assert property (per_req.valid && per_req.unit != 3'h7 && en[per_req.unit]
    |=> !per_fault)
    else $error("fault for clocked unit");
  fault_cause_a: assert property (!per_req.valid |=> !per_fault)
    else $error("fault without request");
endmodule

bind rmcg_top rmcg_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .power_state(power_state),
  .per_req(per_req), .per_fault(per_fault), .unit_clock_en(unit_clock_en));

// ### test/tb_top.sv
`timescale 1ns/100ps
module tb_top import rmcg_pkg::*;;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] power_state = 2'h0;
  rmcg_per_req_s per_req = '0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic per_fault;
  logic irq;
  logic err;
  rmcg_enables_s unit_clock_en;
  int fails = 0;
  int checks = 0;
  int pos [7] = '{RMCG_BIT_SERIAL0, RMCG_BIT_SERIAL1, RMCG_BIT_SYNC0, RMCG_BIT_TWOWIRE0,
    RMCG_BIT_TIMER_UNIT0_CLOCK_ON, RMCG_BIT_TIMER_UNIT1_CLOCK_ON, RMCG_BIT_TIMER_UNIT2_CLOCK_ON};

  always #5 pclk = ~pclk;

  rmcg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_state(power_state), .per_req(per_req),
    .per_fault(per_fault), .unit_clock_en(unit_clock_en), .irq(irq));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // request stands until pready is seen high at a rising edge; the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic settle;
    repeat (3) @(negedge pclk);
  endtask

  task automatic poke(input logic [2:0] u, input logic exp);
    @(posedge pclk);
    per_req <= '{valid: 1'h1, unit: u};
    @(posedge pclk);
    per_req <= '0;
    @(negedge pclk);
    chk("per_fault", {31'h0, per_fault}, {31'h0, exp});
  endtask

  task automatic summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, RMCG_OFF_RUN_GATE, 32'h0);
    chk("run_gate", rd, RMCG_GATE_RESET);
    chk("enables", {25'h0, unit_clock_en}, 32'h0);
    for (int i = 0; i < 7; i++) begin
      apb(1'h1, RMCG_OFF_RUN_GATE, 32'h1 << pos[i]);
      settle();
      chk("enables", {25'h0, unit_clock_en}, 32'h1 << i);
      apb(1'h0, RMCG_OFF_RUN_GATE, 32'h0);
      chk("run_gate", rd, 32'h1 << pos[i]);
      poke(3'(i), 1'h0);
      poke(3'((i + 1) % 7), 1'h1);
    end
    apb(1'h1, RMCG_OFF_RUN_GATE, 32'hffffffff);
    apb(1'h0, RMCG_OFF_RUN_GATE, 32'h0);
    chk("run_gate", rd, RMCG_GATE_WMASK);
    apb(1'h1, RMCG_OFF_FAULT_MASK, 32'h1);
    apb(1'h1, RMCG_OFF_RUN_GATE, 32'h0);
    poke(3'h3, 1'h1);
    settle();
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'h0, RMCG_OFF_FAULT_STAT, 32'h0);
    chk("fault_stat", rd, 32'h1);
    apb(1'h1, RMCG_OFF_FAULT_STAT, 32'h1);
    settle();
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1'h0, RMCG_OFF_FAULT_STAT, 32'h0);
    chk("fault_stat", rd, 32'h0);
    apb(1'h1, RMCG_OFF_FAULT_MASK, 32'h0);
    poke(3'h3, 1'h1);
    settle();
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1'h0, 12'h108, 32'h0);
    chk("pslverr", {31'h0, err}, 32'h1);
    chk("unmapped", rd, 32'h0);
    apb(1'h0, RMCG_OFF_RUN_GATE, 32'h0);
    apb(1'h1, RMCG_OFF_RUN_GATE, (rd & ~RMCG_GATE_WMASK) | 32'h1);
    apb(1'h1, RMCG_OFF_SLEEP_GATE, 32'h10);
    apb(1'h1, RMCG_OFF_DEEP_GATE, 32'h10000);
    power_state <= RMCG_PWR_SLEEP;
    settle();
    chk("enables", {25'h0, unit_clock_en}, 32'h1);
    apb(1'h1, RMCG_OFF_RUN_CFG, 32'h08000000);
    settle();
    chk("enables", {25'h0, unit_clock_en}, 32'h4);
    power_state <= RMCG_PWR_DEEP;
    settle();
    chk("enables", {25'h0, unit_clock_en}, 32'h10);
    power_state <= RMCG_PWR_RUN;
    settle();
    chk("enables", {25'h0, unit_clock_en}, 32'h1);
    // reset in mid-run must clear every enable again
    apb(1'h1, RMCG_OFF_RUN_GATE, 32'hffffffff);
    settle();
    chk("enables", {25'h0, unit_clock_en}, 32'h7f);
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    chk("enables", {25'h0, unit_clock_en}, 32'h0);
    apb(1'h0, RMCG_OFF_RUN_GATE, 32'h0);
    chk("run_gate", rd, RMCG_GATE_RESET);
    summarize();
  end
endmodule
